//--- hw/pin_mux_pkg.sv
// Shared constants for the port B / port C alternate-function override logic.
// Operation
// - SPI as host forces the data-in pin to input, ignoring its direction bit.
// - SPI as target: data-in pin direction follows its bit, drives target data.
// - Pins forced to input by SPI keep pull-up from port bit and global off.
// - SPI target forces data-out pin to input; as host it follows its bit.
// - SPI target forces select pin to input; a low level selects the SPI.
// - SPI host leaves the select pin direction with its direction bit.
// - Each timer waveform leaves on its compare-match pin when its direction bit is 1 and the SPI does not claim that pin.
// - Clock output enable at 1 forces the clock pin to output.
// - Clock pin toggles at the selected system operating clock rate.
// - Capture pin digital input feeds the 16-bit timer capture.
// - Crystal pins lose pull-up and output when a crystal or async clock is on.
// - After reset the reset-capable pin is the external reset input.
// - With the reset function off, that pin is plain I/O and pin-change source.
// - Two-wire enable hands the clock and data pins to the two-wire port.
// - Every pin except the active reset input is a pin-change source; its input stays on while enabled.
// - Pull-up override enable selects override value, else dir, port, global off.
// - Direction override enable selects override value, else the direction bit.
// - Value override enable selects override value, else the port output bit.
// - Input-enable override selects override value, else sleep state rules.
package pin_mux_pkg;

  localparam int PORT_B_WIDTH = 8;
  localparam int PORT_C_WIDTH = 3;
  localparam int PIN_COUNT    = PORT_B_WIDTH + PORT_C_WIDTH;

  // Port B pin positions.
  localparam int PIN_SYSCLK_OUT = 0;
  localparam int PIN_T1_CMP_A   = 1;
  localparam int PIN_SEL    = 2;
  localparam int PIN_MOSI   = 3;
  localparam int PIN_MISO   = 4;
  localparam int PIN_SCK    = 5;
  localparam int PIN_XTAL1  = 6;
  localparam int PIN_XTAL2  = 7;

  // Port C positions inside the narrow port C vectors (pins 4, 5 and 6).
  localparam int PIN_SDA    = 0;
  localparam int PIN_SCL    = 1;
  localparam int PIN_RESET  = 2;

  // Values taken by every pad-side flip-flop under reset.
  localparam logic RST_PULLUP = 1'b0;
  localparam logic RST_OE     = 1'b0;
  localparam logic RST_OUT    = 1'b0;
  localparam logic RST_DIN_EN = 1'b0;
  localparam logic RST_SYSCLK_PIN = 1'b0;

endpackage : pin_mux_pkg

//--- hw/pin_override_cell.sv
// One pin's override selection for pull-up, direction, value and input enable.
`timescale 1ns/100ps
module pin_override_cell (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic dir_bit,
  input  wire logic port_bit,
  input  wire logic global_pullup_off,
  input  wire logic sleep_clamp,
  input  wire logic pullup_override_en,
  input  wire logic pullup_override_val,
  input  wire logic dir_override_en,
  input  wire logic dir_override_val,
  input  wire logic value_override_en,
  input  wire logic value_override_val,
  input  wire logic input_en_override_en,
  input  wire logic input_en_override_val,
  input  wire logic pad_in,
  output logic      pullup_q,
  output logic      pad_oe_q,
  output logic      pad_out_q,
  output logic      din_en_q,
  output logic      din
);

  wire pullup_d = pullup_override_en ? pullup_override_val
                                     : (~dir_bit & port_bit & ~global_pullup_off);
  wire pad_oe_d = dir_override_en ? dir_override_val : dir_bit;
  wire pad_out_d = value_override_en ? value_override_val : port_bit;
  wire din_en_d = input_en_override_en ? input_en_override_val : ~sleep_clamp;

  // The input gate uses the live enable so a peripheral never sees a stale clamp.
  assign din = pad_in & din_en_d;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pullup_q  <= pin_mux_pkg::RST_PULLUP;
      pad_oe_q  <= pin_mux_pkg::RST_OE;
      pad_out_q <= pin_mux_pkg::RST_OUT;
      din_en_q  <= pin_mux_pkg::RST_DIN_EN;
    end
    else
    begin
      pullup_q  <= pullup_d;
      pad_oe_q  <= pad_oe_d;
      pad_out_q <= pad_out_d;
      din_en_q  <= din_en_d;
    end
  end

endmodule : pin_override_cell

//--- hw/port_b_c_alt_function_mux.sv
// Alternate-function override mux for port B and port C pins 4 to 6.
`timescale 1ns/100ps
module port_b_c_alt_function_mux #(
  parameter int NB = pin_mux_pkg::PORT_B_WIDTH,
  parameter int NC = pin_mux_pkg::PORT_C_WIDTH
) (
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire logic [NB-1:0] dir_b,
  input  wire logic [NB-1:0] port_b,
  input  wire logic [NC-1:0] dir_c,
  input  wire logic [NC-1:0] port_c,
  input  wire logic          global_pullup_off,
  input  wire logic          sleep_clamp,
  input  wire logic [NB-1:0] pin_change_irq_en_b,
  input  wire logic [NC-1:0] pin_change_irq_en_c,
  input  wire logic          spi_block_on,
  input  wire logic          spi_host_select,
  input  wire logic          spi_sck_out,
  input  wire logic          spi_host_data_out,
  input  wire logic          spi_target_data_out,
  input  wire logic          t1_compare_out_a,
  input  wire logic          t1_compare_a_on,
  input  wire logic          t1_compare_out_b,
  input  wire logic          t1_compare_b_on,
  input  wire logic          t2_compare_out_a,
  input  wire logic          t2_compare_a_on,
  input  wire logic          sysclk_pin_enable,
  input  wire logic          sysclk_src,
  input  wire logic          high_speed_crystal_on,
  input  wire logic          low_speed_crystal_on,
  input  wire logic          async_timer_clock_sel,
  input  wire logic          reset_pin_release,
  input  wire logic          two_wire_on,
  input  wire logic          two_wire_scl_oe,
  input  wire logic          two_wire_sda_oe,
  input  wire logic [NB-1:0] pad_in_b,
  input  wire logic [NC-1:0] pad_in_c,
  output logic      [NB-1:0] pad_out_b,
  output logic      [NB-1:0] pad_oe_b,
  output logic      [NB-1:0] pullup_b,
  output logic      [NB-1:0] din_en_b,
  output logic      [NC-1:0] pad_out_c,
  output logic      [NC-1:0] pad_oe_c,
  output logic      [NC-1:0] pullup_c,
  output logic      [NC-1:0] din_en_c,
  output logic      [NB-1:0] pin_change_irq_b,
  output logic      [NC-1:0] pin_change_irq_c,
  output logic               spi_sck_in,
  output logic               spi_host_data_in,
  output logic               spi_target_data_in,
  output logic               spi_select_in_n,
  output logic               t1_capture_in,
  output logic               ext_reset_in_n,
  output logic               two_wire_scl_in,
  output logic               two_wire_sda_in
);

  localparam int NP = NB + NC;

  wire spi_host   = spi_block_on & spi_host_select;
  wire spi_target = spi_block_on & ~spi_host_select;
  wire crystal_pins_claim = high_speed_crystal_on | low_speed_crystal_on
                          | async_timer_clock_sel;
  wire reset_fn = ~reset_pin_release;

  wire [NP-1:0] dir_all  = {dir_c, dir_b};
  wire [NP-1:0] port_all = {port_c, port_b};
  wire [NP-1:0] pad_all  = {pad_in_c, pad_in_b};
  wire [NP-1:0] pci_en   = {pin_change_irq_en_c, pin_change_irq_en_b};

  logic [NP-1:0] pullup_override_en;
  logic [NP-1:0] pullup_override_val;
  logic [NP-1:0] dir_override_en;
  logic [NP-1:0] dir_override_val;
  logic [NP-1:0] value_override_en;
  logic [NP-1:0] value_override_val;
  logic [NP-1:0] input_en_override_en;
  logic [NP-1:0] input_en_override_val;
  logic [NP-1:0] pull_q;
  logic [NP-1:0] oe_q;
  logic [NP-1:0] out_q;
  logic [NP-1:0] die_q;
  logic [NP-1:0] din;
  logic          sysclk_pin_q;

  // Pins forced to input by SPI, and the two-wire pins, keep the ordinary port-bit pull-up under the global off.
  wire pu_keep_sck  = port_b[pin_mux_pkg::PIN_SCK] & ~global_pullup_off;
  wire pu_keep_miso = port_b[pin_mux_pkg::PIN_MISO] & ~global_pullup_off;
  wire pu_keep_mosi = port_b[pin_mux_pkg::PIN_MOSI] & ~global_pullup_off;
  wire pu_keep_sel  = port_b[pin_mux_pkg::PIN_SEL] & ~global_pullup_off;
  wire pu_keep_sda  = port_c[pin_mux_pkg::PIN_SDA] & ~global_pullup_off;
  wire pu_keep_scl  = port_c[pin_mux_pkg::PIN_SCL] & ~global_pullup_off;

  localparam int B0 = pin_mux_pkg::PIN_SYSCLK_OUT;
  localparam int B1 = pin_mux_pkg::PIN_T1_CMP_A;
  localparam int B2 = pin_mux_pkg::PIN_SEL;
  localparam int B3 = pin_mux_pkg::PIN_MOSI;
  localparam int B4 = pin_mux_pkg::PIN_MISO;
  localparam int B5 = pin_mux_pkg::PIN_SCK;
  localparam int B6 = pin_mux_pkg::PIN_XTAL1;
  localparam int B7 = pin_mux_pkg::PIN_XTAL2;
  localparam int C4 = NB + pin_mux_pkg::PIN_SDA;
  localparam int C5 = NB + pin_mux_pkg::PIN_SCL;
  localparam int C6 = NB + pin_mux_pkg::PIN_RESET;

  // Pull-up override per pin.
  assign pullup_override_en[B0] = 1'b0;
  assign pullup_override_en[B1] = 1'b0;
  assign pullup_override_en[B2] = spi_target;
  assign pullup_override_en[B3] = spi_target;
  assign pullup_override_en[B4] = spi_host;
  assign pullup_override_en[B5] = spi_target;
  assign pullup_override_en[B6] = crystal_pins_claim;
  assign pullup_override_en[B7] = crystal_pins_claim;
  assign pullup_override_en[C4] = two_wire_on;
  assign pullup_override_en[C5] = two_wire_on;
  assign pullup_override_en[C6] = reset_fn;
  assign pullup_override_val = {1'b1, pu_keep_scl, pu_keep_sda, 1'b0, 1'b0, pu_keep_sck,
                                pu_keep_miso, pu_keep_mosi, pu_keep_sel, 1'b0, 1'b0};

  // Direction override per pin; compare outputs leave direction to software.
  assign dir_override_en[B0] = sysclk_pin_enable;
  assign dir_override_en[B1] = 1'b0;
  assign dir_override_en[B2] = spi_target;
  assign dir_override_en[B3] = spi_target;
  assign dir_override_en[B4] = spi_host;
  assign dir_override_en[B5] = spi_target;
  assign dir_override_en[B6] = crystal_pins_claim;
  assign dir_override_en[B7] = crystal_pins_claim;
  assign dir_override_en[C4] = two_wire_on;
  assign dir_override_en[C5] = two_wire_on;
  assign dir_override_en[C6] = reset_fn;
  assign dir_override_val = {1'b0, two_wire_scl_oe, two_wire_sda_oe, 7'h00, 1'b1};

  // Value override per pin.
  assign value_override_en[B0] = sysclk_pin_enable;
  assign value_override_en[B1] = t1_compare_a_on;
  assign value_override_en[B2] = t1_compare_b_on;
  assign value_override_en[B3] = spi_host | t2_compare_a_on;
  assign value_override_en[B4] = spi_target;
  assign value_override_en[B5] = spi_host;
  assign value_override_en[B6] = 1'b0;
  assign value_override_en[B7] = 1'b0;
  assign value_override_en[C4] = two_wire_on;
  assign value_override_en[C5] = two_wire_on;
  assign value_override_en[C6] = reset_fn;
  wire mosi_val = spi_host ? spi_host_data_out : t2_compare_out_a;
  // The clock pin value is added after the flops, so its cell value stays low.
  assign value_override_val = {1'b1, 1'b0, 1'b0, 1'b0, 1'b0, spi_sck_out,
                               spi_target_data_out, mosi_val, t1_compare_out_b,
                               t1_compare_out_a, 1'b0};

  // Input enable stays on while a pin's change interrupt, the reset input or the two-wire port needs it.
  assign input_en_override_en = pci_en | {reset_fn, two_wire_on, two_wire_on, 8'h00};
  assign input_en_override_val = {NP{1'b1}};

  genvar g;
  generate
    for (g = 0; g < NP; g++)
    begin : g_pin
      pin_override_cell u_cell (
        .clock                 (clock),
        .rst                   (rst),
        .dir_bit               (dir_all[g]),
        .port_bit              (port_all[g]),
        .global_pullup_off     (global_pullup_off),
        .sleep_clamp           (sleep_clamp),
        .pullup_override_en    (pullup_override_en[g]),
        .pullup_override_val   (pullup_override_val[g]),
        .dir_override_en       (dir_override_en[g]),
        .dir_override_val      (dir_override_val[g]),
        .value_override_en     (value_override_en[g]),
        .value_override_val    (value_override_val[g]),
        .input_en_override_en  (input_en_override_en[g]),
        .input_en_override_val (input_en_override_val[g]),
        .pad_in                (pad_all[g]),
        .pullup_q              (pull_q[g]),
        .pad_oe_q              (oe_q[g]),
        .pad_out_q             (out_q[g]),
        .din_en_q              (die_q[g]),
        .din                   (din[g])
      );
    end
  endgenerate

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      sysclk_pin_q <= pin_mux_pkg::RST_SYSCLK_PIN;
    else
      sysclk_pin_q <= sysclk_pin_enable;
  end

  // A clock cannot pass through a flop, so the clock pin gates the live clock.
  // Enabling it mid-phase may give one short first pulse.
  wire sysclk_pin_drive = sysclk_pin_q & sysclk_src;

  assign pad_out_b = out_q[NB-1:0] | {{(NB-1){1'b0}}, sysclk_pin_drive};
  assign pad_oe_b  = oe_q[NB-1:0];
  assign pullup_b  = pull_q[NB-1:0];
  assign din_en_b  = die_q[NB-1:0];
  assign pad_out_c = out_q[NP-1:NB];
  assign pad_oe_c  = oe_q[NP-1:NB];
  assign pullup_c  = pull_q[NP-1:NB];
  assign din_en_c  = die_q[NP-1:NB];

  assign pin_change_irq_b   = din[NB-1:0];
  // While the pin is the reset input it raises no pin-change events.
  assign pin_change_irq_c   = din[NP-1:NB] & {~reset_fn, 2'b11};
  assign spi_sck_in         = din[B5];
  assign spi_host_data_in   = din[B4];
  assign spi_target_data_in = din[B3];
  assign spi_select_in_n    = spi_target ? din[B2] : 1'b1;
  assign t1_capture_in      = din[B0];
  assign ext_reset_in_n     = reset_fn ? pad_in_c[pin_mux_pkg::PIN_RESET] : 1'b1;
  assign two_wire_sda_in    = din[C4];
  assign two_wire_scl_in    = din[C5];

  chk_miso_host_input: assert property (
    @(posedge clock) disable iff (rst) spi_host |=> !pad_oe_b[B4])
    else $error("data-in pin drives while SPI is host");

  chk_miso_target_dir: assert property (
    @(posedge clock) disable iff (rst) spi_target |=>
      pad_oe_b[B4] == $past(dir_b[B4]) && pad_out_b[B4] == $past(spi_target_data_out))
    else $error("target data pin does not follow its direction bit");

  chk_forced_pullup: assert property (
    @(posedge clock) disable iff (rst) spi_host |=>
      pullup_b[B4] == ($past(port_b[B4]) && !$past(global_pullup_off)))
    else $error("forced-input pull-up not from port bit");

  chk_mosi_dir: assert property (
    @(posedge clock) disable iff (rst) spi_target |=> !pad_oe_b[B3])
    else $error("data-out pin drives while SPI is target");

  chk_select_low: assert property (
    @(posedge clock) disable iff (rst)
      spi_target && (pin_change_irq_en_b[B2] || !sleep_clamp) |->
        spi_select_in_n == pad_in_b[B2])
    else $error("select input not taken from pin");

  chk_select_host_dir: assert property (
    @(posedge clock) disable iff (rst) spi_host |=> pad_oe_b[B2] == $past(dir_b[B2]))
    else $error("select pin direction overridden in host mode");

  chk_compare_a_value: assert property (
    @(posedge clock) disable iff (rst)
      t1_compare_a_on ##1 t1_compare_a_on |-> pad_out_b[B1] == $past(t1_compare_out_a))
    else $error("compare A level missing on its pin");

  chk_clock_pin_oe: assert property (
    @(posedge clock) disable iff (rst) sysclk_pin_enable |=> pad_oe_b[B0])
    else $error("clock pin not forced to output");

  chk_capture_path: assert property (
    @(posedge clock) disable iff (rst)
      pin_change_irq_en_b[B0] |-> t1_capture_in == pad_in_b[B0])
    else $error("capture input not the pin level");

  chk_crystal_claim: assert property (
    @(posedge clock) disable iff (rst) crystal_pins_claim |=>
      !pad_oe_b[B6] && !pad_oe_b[B7] && !pullup_b[B6] && !pullup_b[B7])
    else $error("crystal pins not released");

  chk_reset_pin_in: assert property (
    @(posedge clock) disable iff (rst) reset_fn |=> !pad_oe_c[pin_mux_pkg::PIN_RESET]
      && pullup_c[pin_mux_pkg::PIN_RESET])
    else $error("reset pin not held as pulled-up input");

  chk_two_wire_dir: assert property (
    @(posedge clock) disable iff (rst) two_wire_on |=>
      pad_oe_c[pin_mux_pkg::PIN_SCL] == $past(two_wire_scl_oe)
      && pad_out_c[pin_mux_pkg::PIN_SCL] == 1'b0)
    else $error("two-wire port does not own the clock pin");

  chk_pci_input_on: assert property (
    @(posedge clock) disable iff (rst) pin_change_irq_en_b[B5] |=> din_en_b[B5])
    else $error("input disabled on an enabled change pin");

  chk_reset_pin_gpio: assert property (
    @(posedge clock) disable iff (rst)
      !reset_fn && pin_change_irq_en_c[pin_mux_pkg::PIN_RESET] |-> ext_reset_in_n
      && pin_change_irq_c[pin_mux_pkg::PIN_RESET] == pad_in_c[pin_mux_pkg::PIN_RESET])
    else $error("reset-capable pin not released to plain use");

  chk_clock_pin_level: assert property (
    @(posedge clock) disable iff (rst)
      sysclk_pin_enable ##1 sysclk_pin_enable |-> pad_out_b[B0] == sysclk_src)
    else $error("clock pin does not follow the system clock");

  chk_plain_pullup: assert property (
    @(posedge clock) disable iff (rst)
      1'b1 |=> pullup_b[B1] == ($past(port_b[B1]) && !$past(dir_b[B1])
        && !$past(global_pullup_off)))
    else $error("plain pin pull-up not from direction, port and global off");

  chk_plain_dir: assert property (
    @(posedge clock) disable iff (rst) 1'b1 |=> pad_oe_b[B1] == $past(dir_b[B1]))
    else $error("plain pin direction not from its direction bit");

  chk_plain_value: assert property (
    @(posedge clock) disable iff (rst)
      !t1_compare_a_on |=> pad_out_b[B1] == $past(port_b[B1]))
    else $error("plain pin value not from its port bit");

  chk_sleep_clamp: assert property (
    @(posedge clock) disable iff (rst)
      sleep_clamp && !pin_change_irq_en_b[B1] |=> !din_en_b[B1])
    else $error("input enable not clamped in sleep");

endmodule : port_b_c_alt_function_mux

//--- tb/pad_peripheral_model.sv
// Pin-side model that resolves every pad from the block's drive, pull-ups and outside drivers.
`timescale 1ns/100ps
module pad_peripheral_model #(
  parameter int NB = 8,
  parameter int NC = 3
) (
  input  wire logic          clock,
  input  wire logic [NB-1:0] pad_oe_b,
  input  wire logic [NB-1:0] pad_out_b,
  input  wire logic [NB-1:0] pullup_b,
  input  wire logic [NB-1:0] ext_b,
  input  wire logic [NB-1:0] ext_en_b,
  input  wire logic [NC-1:0] pad_oe_c,
  input  wire logic [NC-1:0] pad_out_c,
  input  wire logic [NC-1:0] pullup_c,
  input  wire logic [NC-1:0] ext_c,
  input  wire logic [NC-1:0] ext_en_c,
  output logic      [NB-1:0] pad_in_b,
  output logic      [NC-1:0] pad_in_c
);
  logic [NB-1:0] last_b_q;
  logic [NC-1:0] last_c_q;
  logic [NC-1:0] pull_c;
  // The reused reset pin carries an outside pull-up so it never floats during power-up.
  assign pull_c = {1'b1, pullup_c[NC-2:0]};
  // A floating pad shows the inverse of its last level, so a stale value is never read as good.
  assign pad_in_b = (pad_oe_b & pad_out_b) | (~pad_oe_b & ext_en_b & ext_b)
                  | (~pad_oe_b & ~ext_en_b & (pullup_b | ~last_b_q));
  assign pad_in_c = (pad_oe_c & pad_out_c) | (~pad_oe_c & ext_en_c & ext_c)
                  | (~pad_oe_c & ~ext_en_c & (pull_c | ~last_c_q));
  always_ff @(posedge clock)
  begin
    last_b_q <= pad_in_b;
    last_c_q <= pad_in_c;
  end
endmodule : pad_peripheral_model

//--- tb/port_b_c_alt_function_mux_tb.sv
// Self-checking bench for the port B / port C alternate-function mux.
`timescale 1ns/100ps
module port_b_c_alt_function_mux_tb;
  logic       clock, rst, global_pullup_off, sleep_clamp, spi_block_on, spi_host_select;
  logic       spi_sck_out, spi_host_data_out, spi_target_data_out, sysclk_pin_enable;
  logic       t1_compare_out_a, t1_compare_a_on, t1_compare_out_b, t1_compare_b_on;
  logic       t2_compare_out_a, t2_compare_a_on, sysclk_src, high_speed_crystal_on;
  logic       low_speed_crystal_on, async_timer_clock_sel, reset_pin_release;
  logic       two_wire_on, two_wire_scl_oe, two_wire_sda_oe;
  logic [7:0] dir_b, port_b, pin_change_irq_en_b, pad_in_b, pad_out_b, pad_oe_b, pullup_b;
  logic [7:0] din_en_b, pin_change_irq_b, ext_b, ext_en_b;
  logic [2:0] dir_c, port_c, pin_change_irq_en_c, pad_in_c, pad_out_c, pad_oe_c, pullup_c;
  logic [2:0] din_en_c, pin_change_irq_c, ext_c, ext_en_c;
  logic       spi_sck_in, spi_host_data_in, spi_target_data_in, spi_select_in_n;
  logic       t1_capture_in, ext_reset_in_n, two_wire_scl_in, two_wire_sda_in;
  int         n_mismatch, comparisons;

  port_b_c_alt_function_mux u_dut (
    .clock, .rst, .dir_b, .port_b, .dir_c, .port_c, .global_pullup_off, .sleep_clamp,
    .pin_change_irq_en_b, .pin_change_irq_en_c, .spi_block_on, .spi_host_select,
    .spi_sck_out, .spi_host_data_out, .spi_target_data_out, .t1_compare_out_a,
    .t1_compare_a_on, .t1_compare_out_b, .t1_compare_b_on, .t2_compare_out_a,
    .t2_compare_a_on, .sysclk_pin_enable, .sysclk_src, .high_speed_crystal_on,
    .low_speed_crystal_on, .async_timer_clock_sel, .reset_pin_release, .two_wire_on,
    .two_wire_scl_oe, .two_wire_sda_oe, .pad_in_b, .pad_in_c, .pad_out_b, .pad_oe_b,
    .pullup_b, .din_en_b, .pad_out_c, .pad_oe_c, .pullup_c, .din_en_c, .pin_change_irq_b,
    .pin_change_irq_c, .spi_sck_in, .spi_host_data_in, .spi_target_data_in,
    .spi_select_in_n, .t1_capture_in, .ext_reset_in_n, .two_wire_scl_in, .two_wire_sda_in
  );
  pad_peripheral_model u_pads (
    .clock, .pad_oe_b, .pad_out_b, .pullup_b, .ext_b, .ext_en_b, .pad_oe_c, .pad_out_c,
    .pullup_c, .ext_c, .ext_en_c, .pad_in_b, .pad_in_c
  );

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic step();
    @(posedge clock);
    #1;
  endtask : step

  task automatic chk(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic final_report();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  task automatic test_reset();
    chk8(pad_oe_b | pullup_b | din_en_b | pad_out_b, 8'h00);
    chk(ext_reset_in_n, 1'b0);
    step();
    ext_c = 3'h4;
    step();
    chk(ext_reset_in_n, 1'b1);
    repeat (4) step();
    rst = 1'b0;
    $display("test reset done");
  endtask : test_reset

  task automatic test_spi_host();
    spi_block_on = 1'b1;
    spi_host_select = 1'b1;
    dir_b = 8'h1c;
    port_b = 8'h10;
    spi_host_data_out = 1'b1;
    ext_b = 8'h10;
    step();
    chk(pad_oe_b[4], 1'b0);
    chk(pullup_b[4], 1'b1);
    chk(spi_host_data_in, 1'b1);
    chk(pad_oe_b[2], 1'b1);
    chk(spi_select_in_n, 1'b1);
    chk(pad_oe_b[3], 1'b1);
    chk(pad_out_b[3], 1'b1);
    global_pullup_off = 1'b1;
    step();
    chk(pullup_b[4], 1'b0);
    global_pullup_off = 1'b0;
    $display("test spi_host done");
  endtask : test_spi_host

  task automatic test_spi_target();
    spi_host_select = 1'b0;
    port_b = 8'h08;
    spi_target_data_out = 1'b1;
    ext_b = 8'h28;
    step();
    chk(spi_sck_in, 1'b1);
    chk(pad_oe_b[3], 1'b0);
    chk(pullup_b[3], 1'b1);
    chk(spi_target_data_in, 1'b1);
    chk(pad_oe_b[2], 1'b0);
    chk(pad_oe_b[4], 1'b1);
    chk(pad_out_b[4], 1'b1);
    chk(spi_select_in_n, 1'b0);
    ext_b = 8'h2c;
    step();
    chk(spi_select_in_n, 1'b1);
    spi_block_on = 1'b0;
    $display("test spi_target done");
  endtask : test_spi_target

  task automatic test_compare();
    dir_b = 8'h0e;
    port_b = 8'h0e;
    {t1_compare_a_on, t1_compare_b_on, t2_compare_a_on} = 3'h7;
    for (int v = 0; v < 2; v++)
    begin
      t1_compare_out_a = v[0];
      t1_compare_out_b = ~v[0];
      t2_compare_out_a = v[0];
      step();
      chk(pad_out_b[1], v[0]);
      chk(pad_out_b[2], ~v[0]);
      chk(pad_out_b[3], v[0]);
    end
    {t1_compare_a_on, t1_compare_b_on, t2_compare_a_on} = 3'h0;
    $display("test compare done");
  endtask : test_compare

  task automatic test_clock_out();
    dir_b = 8'h00;
    sysclk_pin_enable = 1'b1;
    sysclk_src = 1'b1;
    step();
    chk(pad_oe_b[0], 1'b1);
    chk(pad_out_b[0], 1'b1);
    sysclk_src = 1'b0;
    step();
    chk(pad_out_b[0], 1'b0);
    sysclk_src = 1'b1;
    step();
    chk(pad_out_b[0], 1'b1);
    step();
    sysclk_pin_enable = 1'b0;
    sysclk_src = 1'b0;
    pin_change_irq_en_b = 8'h01;
    ext_b = 8'h01;
    step();
    chk(t1_capture_in, 1'b1);
    chk(din_en_b[0], 1'b1);
    ext_b = 8'h00;
    step();
    chk(t1_capture_in, 1'b0);
    $display("test clock_out done");
  endtask : test_clock_out

  task automatic test_crystal();
    dir_b = 8'hc0;
    port_b = 8'hc0;
    for (int i = 0; i < 3; i++)
    begin
      {high_speed_crystal_on, low_speed_crystal_on, async_timer_clock_sel} = 3'(1 << i);
      step();
      chk(|pad_oe_b[7:6], 1'b0);
      chk(|pullup_b[7:6], 1'b0);
    end
    {high_speed_crystal_on, low_speed_crystal_on, async_timer_clock_sel} = 3'h0;
    step();
    chk8(pad_oe_b, 8'hc0);
    $display("test crystal done");
  endtask : test_crystal

  task automatic test_reset_pin();
    dir_c = 3'h4;
    port_c = 3'h4;
    pin_change_irq_en_c = 3'h4;
    ext_c = 3'h0;
    step();
    chk(pad_oe_c[2], 1'b0);
    chk(ext_reset_in_n, 1'b0);
    chk(pin_change_irq_c[2], 1'b0);
    reset_pin_release = 1'b1;
    ext_en_c = 3'h3;
    step();
    chk(pad_oe_c[2], 1'b1);
    chk(pad_out_c[2], 1'b1);
    chk(ext_reset_in_n, 1'b1);
    chk(pin_change_irq_c[2], 1'b1);
    $display("test reset_pin done");
  endtask : test_reset_pin

  task automatic test_two_wire();
    two_wire_on = 1'b1;
    two_wire_scl_oe = 1'b1;
    dir_c = 3'h0;
    port_c = 3'h3;
    ext_en_c = 3'h0;
    step();
    chk(pad_oe_c[1], 1'b1);
    chk(pad_out_c[1], 1'b0);
    chk(two_wire_scl_in, 1'b0);
    chk(pad_oe_c[0], 1'b0);
    chk(two_wire_sda_in, 1'b1);
    chk(pullup_c[0], 1'b1);
    chk(din_en_c[1], 1'b1);
    $display("test two_wire done");
  endtask : test_two_wire

  task automatic test_gpio();
    two_wire_on = 1'b0;
    two_wire_scl_oe = 1'b0;
    dir_b = 8'h00;
    port_b = 8'h02;
    pin_change_irq_en_b = 8'h00;
    sleep_clamp = 1'b1;
    step();
    chk(pullup_b[1], 1'b1);
    chk(din_en_b[1], 1'b0);
    pin_change_irq_en_b = 8'h22;
    global_pullup_off = 1'b1;
    step();
    chk(pullup_b[1], 1'b0);
    chk(din_en_b[1], 1'b1);
    dir_b = 8'h02;
    step();
    chk(pad_oe_b[1], 1'b1);
    chk(pad_out_b[1], 1'b1);
    chk(pin_change_irq_b[1], 1'b1);
    $display("test gpio done");
  endtask : test_gpio

  initial
  begin
    {global_pullup_off, sleep_clamp, spi_block_on, spi_host_select, spi_sck_out,
     spi_host_data_out, spi_target_data_out, sysclk_pin_enable, t1_compare_out_a,
     t1_compare_a_on, t1_compare_out_b, t1_compare_b_on, t2_compare_out_a, t2_compare_a_on,
     sysclk_src, high_speed_crystal_on, low_speed_crystal_on, async_timer_clock_sel,
     reset_pin_release, two_wire_on, two_wire_scl_oe, two_wire_sda_oe} = '0;
    {dir_b, port_b, pin_change_irq_en_b, ext_b} = '0;
    {dir_c, port_c, pin_change_irq_en_c, ext_c} = '0;
    ext_en_b = 8'hff;
    ext_en_c = 3'h7;
    rst = 1'b1;
    n_mismatch = 0;
    comparisons = 0;
    repeat (10) step();
    test_reset();
    test_spi_host();
    test_spi_target();
    test_compare();
    test_clock_out();
    test_crystal();
    test_reset_pin();
    test_two_wire();
    test_gpio();
    final_report();
  end

  initial
  begin
    #100000;
    n_mismatch++;
    final_report();
  end
endmodule : port_b_c_alt_function_mux_tb
